// *** mme_pkg.sv ***
// Purpose: shared constants and types of the monitor-mode entry and serial link block
// Assumes: clk is the input (oscillator) clock at 100 MHz; bus clock is a divided enable
// Notes: the block's timing, divider, vector and register constants live here
package mme_pkg;

    // bit timing in bus clock cycles; frame, data and delay terminal counts in bits; security byte count
    localparam int unsigned BAUD_BUS_CYCLES = 278;
    localparam logic [8:0] BIT_LAST = 9'(BAUD_BUS_CYCLES - 1);
    localparam logic [8:0] HALF_BIT_LAST = 9'(BAUD_BUS_CYCLES / 2 - 1);
    localparam logic [3:0] FRAME_LAST = 4'h9;
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [3:0] DELAY_LAST = 4'h1;
    localparam logic [3:0] SEC_BYTES = 4'h8;

    // input clock to bus clock divider, as terminal counts
    localparam logic [1:0] DIV2_LAST = 2'h1;
    localparam logic [1:0] DIV4_LAST = 2'h3;

    // vector addresses
    localparam logic [15:0] USER_RESET_VEC = 16'hFFFE;
    localparam logic [15:0] USER_SWI_VEC = 16'hFFFC;
    localparam logic [15:0] MON_RESET_VEC = 16'hFEFE;
    localparam logic [15:0] MON_SWI_VEC = 16'hFEFC;

    // register port map
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_LAST_RX = 4'h1;
    localparam logic [3:0] REG_SEC_BASE = 4'h8;
    localparam int unsigned ST_MONITOR = 0;
    localparam int unsigned ST_FORCED = 1;
    localparam int unsigned ST_UNLOCKED = 2;
    localparam int unsigned ST_BREAK_SENT = 3;
    localparam int unsigned ST_SEC_CNT = 4;
    localparam logic [7:0] RESERVED_READ = 8'h00;

    // pin levels seen while the reset pin rises
    typedef struct packed {
        logic irq_tst;
        logic rst_tst;
        logic div_sel;
        logic ser_sel;
        logic mod0;
        logic mod1;
        logic vec_blank;
    } mme_strap_t;

    // mode outputs
    typedef struct packed {
        logic monitor;
        logic forced;
        logic osc_bypass;
        logic wd_disable;
        logic div4;
    } mme_mode_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_START = 3'h1,
        RX_DATA = 3'h2,
        RX_STOP = 3'h3,
        RX_WAIT = 3'h4
    } mme_rx_st_t;

    typedef enum logic [2:0] {
        SQ_OFF = 3'h0,
        SQ_SEC = 3'h1,
        SQ_DELAY = 3'h2,
        SQ_TX = 3'h3,
        SQ_CMD = 3'h4
    } mme_seq_st_t;

endpackage

// *** mme_sec_mem.sv ***
// Purpose: eight stored security bytes, one write port, one registered read port
// Assumes: single clock, clock enable freezes contents and read register
// Notes: contents have no reset value; software loads them before entry
`timescale 1ns/100ps
`default_nettype none
module mme_sec_mem (
    input wire logic clk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem_ff [0:7];

    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            rd_data <= mem_ff[rd_addr];
        end
    end
endmodule
`default_nettype wire

// *** mme_top.sv ***
// Purpose: monitor-mode entry latch, clock/watchdog/vector selection and single-wire echo link
// Assumes: pins are synchronous to clk; comm pin is wired-OR with an external pullup
// Notes: rx is ignored while the device itself drives the line
// Notes on behaviour
// [RL1] one wired-OR pin carries all traffic
// [RL2] host supplies test voltage, divider low, 4 MHz
// [RL3] mode latched on reset pin rising edge
// [RL4] eight security bytes, then ten-zero break
// [RL5] test voltage entry: bus clock divide two/four
// [RL6] divider low: oscillator halving stage bypassed
// [RL7] watchdog off while test voltage on pin
// [RL8] forced mode ignores port B strap pins
// [RL9] forced mode: bus clock input divided four
// [RL10] forced mode: watchdog always disabled
// [RL11] blank vector entry adds one reset cycle
// [RL12] monitor vectors taken from monitor page
// [RL13] NRZ framing, same rate both directions
// [RL14] bit time is 278 bus cycles
// [RL15] host holds serial select, mode pins
// [RL16] user mode keeps watchdog enabled
// [RL17] security bytes compared with stored bytes
// [RL18] on break: drive high two bits, echo
// [RL19] every received byte echoed back
`timescale 1ns/100ps
`default_nettype none
module mme_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic reset_pin_n,
    input wire mme_pkg::mme_strap_t strap,
    input wire logic comm_in,
    output logic comm_out,
    output logic comm_oe_n,
    output mme_pkg::mme_mode_t mode,
    output logic [15:0] reset_vec,
    output logic [15:0] swi_brk_vec,
    output logic extra_reset,
    output logic unlocked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic rst_q_ff;
    logic [1:0] div_cnt_ff;
    logic extra_done_ff;
    mme_pkg::mme_rx_st_t rx_st_ff;
    logic [8:0] rx_cnt_ff;
    logic [3:0] rx_bits_ff;
    logic [7:0] rx_shift_ff;
    logic rx_byte_ff;
    logic rx_brk_ff;
    mme_pkg::mme_seq_st_t sq_st_ff;
    logic [8:0] tx_cnt_ff;
    logic [3:0] tx_bits_ff;
    logic [9:0] tx_shift_ff;
    logic tx_brk_ff;
    logic hold_hi_ff;
    logic brk_sent_ff;
    logic [3:0] sec_cnt_ff;
    logic sec_bad_ff;
    logic [7:0] last_rx_ff;
    logic [7:0] sec_byte;
    logic rise;
    logic normal_entry;
    logic forced_entry;
    logic bus_tick;
    logic tx_tick;
    logic rx_on;
    logic sec_wr;
    logic nxt_out;
    logic nxt_oe_n;

    assign rise = reset_pin_n && !rst_q_ff;
    // port B straps only count with test voltage on the interrupt pin
    assign normal_entry = strap.irq_tst && !strap.ser_sel && strap.mod0 && !strap.mod1 && comm_in; // [RL3]
    assign forced_entry = !strap.irq_tst && strap.vec_blank && !strap.ser_sel && comm_in; // [RL8]
    assign bus_tick = (div_cnt_ff == 2'h0);
    assign tx_tick = bus_tick && (tx_cnt_ff == 9'h000);
    // half duplex: our own drive would read back as traffic
    assign rx_on = (sq_st_ff == mme_pkg::SQ_SEC) || (sq_st_ff == mme_pkg::SQ_CMD);
    assign sec_wr = reg_wr && reg_addr[3];

    mme_sec_mem u_sec_mem (
        .clk(clk),
        .ce(ce),
        .wr_en(sec_wr),
        .wr_addr(reg_addr[2:0]),
        .wr_data(reg_wdata),
        .rd_addr(sec_cnt_ff[2:0]),
        .rd_data(sec_byte)
    );

    // mode latch on the reset pin rising edge; later strap changes move only wd_disable, in non-forced monitor mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q_ff <= 1'b0;
            mode <= '0;
        end else if (ce) begin
            rst_q_ff <= reset_pin_n;
            if (rise) begin
                mode.monitor <= normal_entry || forced_entry; // [RL3]
                mode.forced <= forced_entry;
                mode.osc_bypass <= normal_entry && !strap.div_sel; // [RL6]
                mode.div4 <= !(normal_entry && !strap.div_sel); // [RL5] [RL9]
            end
            if (mode.forced) begin
                mode.wd_disable <= 1'b1; // [RL10]
            end else if (mode.monitor) begin
                mode.wd_disable <= strap.irq_tst || strap.rst_tst; // [RL7]
            end else begin
                mode.wd_disable <= 1'b0; // [RL16]
            end
        end
    end

    a_forced_div4: assert property (ce && rise && forced_entry |=> mode.div4 && mode.forced && mode.monitor) // [RL9]
        else $error("forced entry did not select divide by four");
    a_bypass_div2: assert property (ce && rise && normal_entry && !strap.div_sel |=> mode.osc_bypass && !mode.div4) // [RL6]
        else $error("divider low entry did not bypass halving stage");
    a_user_wdog: assert property (ce && !mode.monitor |=> !mode.wd_disable) // [RL16]
        else $error("watchdog disabled outside monitor mode");
    a_forced_wdog: assert property (ce && mode.forced && $stable(mode.forced) |=> mode.wd_disable) // [RL10]
        else $error("watchdog enabled in forced monitor mode");

    // monitor vectors replace the user page ones
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reset_vec <= mme_pkg::USER_RESET_VEC;
            swi_brk_vec <= mme_pkg::USER_SWI_VEC;
        end else if (ce) begin
            reset_vec <= mode.monitor ? mme_pkg::MON_RESET_VEC : mme_pkg::USER_RESET_VEC; // [RL12]
            swi_brk_vec <= mode.monitor ? mme_pkg::MON_SWI_VEC : mme_pkg::USER_SWI_VEC; // [RL12]
        end
    end

    a_mon_vectors: assert property (ce && mode.monitor |=> reset_vec == 16'hFEFE && swi_brk_vec == 16'hFEFC) // [RL12]
        else $error("monitor vectors not selected");

    // one extra reset per power-on when entering with a blank reset vector
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extra_reset <= 1'b0;
            extra_done_ff <= 1'b0;
        end else if (ce) begin
            extra_reset <= rise && forced_entry && !extra_done_ff; // [RL11]
            if (rise && forced_entry) begin
                extra_done_ff <= 1'b1;
            end
        end
    end

    a_extra_once: assert property (ce && extra_reset |=> !extra_reset) // [RL11]
        else $error("extra reset longer than one cycle");

    // bus clock enable from the input clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_ff <= mme_pkg::DIV4_LAST;
        end else if (ce) begin
            if (bus_tick) begin
                div_cnt_ff <= mode.div4 ? mme_pkg::DIV4_LAST : mme_pkg::DIV2_LAST; // [RL5]
            end else begin
                div_cnt_ff <= div_cnt_ff - 2'h1;
            end
        end
    end

    // receiver: start checked at mid-bit, then sampled each bit time
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_st_ff <= mme_pkg::RX_IDLE;
            rx_cnt_ff <= 9'h000;
            rx_bits_ff <= 4'h0;
            rx_shift_ff <= 8'h00;
            rx_byte_ff <= 1'b0;
            rx_brk_ff <= 1'b0;
        end else if (ce) begin
            rx_byte_ff <= 1'b0;
            rx_brk_ff <= 1'b0;
            if (!rx_on || !reset_pin_n) begin
                rx_st_ff <= mme_pkg::RX_IDLE;
            end else if (bus_tick) begin
                rx_cnt_ff <= (rx_cnt_ff == 9'h000) ? mme_pkg::BIT_LAST : rx_cnt_ff - 9'h001; // [RL14]
                unique case (rx_st_ff)
                    mme_pkg::RX_IDLE: begin
                        if (!comm_in) begin
                            rx_st_ff <= mme_pkg::RX_START;
                            rx_cnt_ff <= mme_pkg::HALF_BIT_LAST;
                        end
                    end
                    mme_pkg::RX_START: begin
                        if (rx_cnt_ff == 9'h000) begin
                            rx_st_ff <= comm_in ? mme_pkg::RX_IDLE : mme_pkg::RX_DATA;
                            rx_bits_ff <= 4'h0;
                        end
                    end
                    mme_pkg::RX_DATA: begin
                        if (rx_cnt_ff == 9'h000) begin
                            rx_shift_ff <= {comm_in, rx_shift_ff[7:1]}; // [RL13]
                            rx_bits_ff <= rx_bits_ff + 4'h1;
                            if (rx_bits_ff == mme_pkg::DATA_LAST) begin
                                rx_st_ff <= mme_pkg::RX_STOP;
                            end
                        end
                    end
                    mme_pkg::RX_STOP: begin
                        if (rx_cnt_ff == 9'h000) begin
                            if (comm_in) begin
                                rx_byte_ff <= 1'b1;
                                rx_st_ff <= mme_pkg::RX_IDLE;
                            end else begin
                                rx_brk_ff <= (rx_shift_ff == 8'h00);
                                rx_st_ff <= mme_pkg::RX_WAIT;
                            end
                        end
                    end
                    mme_pkg::RX_WAIT: begin
                        if (comm_in) begin
                            rx_st_ff <= mme_pkg::RX_IDLE;
                        end
                    end
                    default: rx_st_ff <= mme_pkg::RX_IDLE;
                endcase
            end
        end
    end

    a_rx_count: assert property (rx_cnt_ff <= mme_pkg::BIT_LAST) // [RL14]
        else $error("receive bit counter beyond one bit time");

    // sequencer: security bytes, echoes, breaks
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sq_st_ff <= mme_pkg::SQ_OFF;
            tx_cnt_ff <= 9'h000;
            tx_bits_ff <= 4'h0;
            tx_shift_ff <= 10'h3FF;
            tx_brk_ff <= 1'b0;
            hold_hi_ff <= 1'b0;
            brk_sent_ff <= 1'b0;
            sec_cnt_ff <= 4'h0;
        end else if (ce) begin
            if (bus_tick) begin
                tx_cnt_ff <= (tx_cnt_ff == 9'h000) ? mme_pkg::BIT_LAST : tx_cnt_ff - 9'h001; // [RL14]
            end
            if (!reset_pin_n || extra_reset || !mode.monitor) begin
                sq_st_ff <= mme_pkg::SQ_OFF;
            end else begin
                unique case (sq_st_ff)
                    mme_pkg::SQ_OFF: begin
                        sq_st_ff <= brk_sent_ff ? mme_pkg::SQ_CMD : mme_pkg::SQ_SEC; // [RL4]
                    end
                    mme_pkg::SQ_SEC, mme_pkg::SQ_CMD: begin
                        if (rx_byte_ff || rx_brk_ff) begin
                            sq_st_ff <= mme_pkg::SQ_DELAY;
                            tx_bits_ff <= 4'h0;
                            tx_cnt_ff <= mme_pkg::BIT_LAST;
                            tx_brk_ff <= rx_brk_ff;
                            hold_hi_ff <= rx_brk_ff; // [RL18]
                            tx_shift_ff <= rx_brk_ff ? 10'h000 : {1'b1, rx_shift_ff, 1'b0}; // [RL19]
                            if (rx_byte_ff && sq_st_ff == mme_pkg::SQ_SEC) begin
                                sec_cnt_ff <= sec_cnt_ff + 4'h1; // [RL4]
                            end
                        end
                    end
                    mme_pkg::SQ_DELAY: begin
                        if (tx_tick) begin
                            tx_bits_ff <= tx_bits_ff + 4'h1;
                            if (tx_bits_ff == mme_pkg::DELAY_LAST) begin
                                sq_st_ff <= mme_pkg::SQ_TX;
                                tx_bits_ff <= 4'h0;
                                hold_hi_ff <= 1'b0;
                            end
                        end
                    end
                    mme_pkg::SQ_TX: begin
                        if (tx_tick) begin
                            tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
                            tx_bits_ff <= tx_bits_ff + 4'h1;
                            if (tx_bits_ff == mme_pkg::FRAME_LAST) begin
                                tx_bits_ff <= 4'h0;
                                if (sec_cnt_ff == mme_pkg::SEC_BYTES && !brk_sent_ff) begin
                                    // readiness break follows the last security echo
                                    sq_st_ff <= mme_pkg::SQ_DELAY; // [RL4]
                                    tx_brk_ff <= 1'b1;
                                    tx_shift_ff <= 10'h000;
                                    brk_sent_ff <= 1'b1;
                                end else begin
                                    sq_st_ff <= brk_sent_ff ? mme_pkg::SQ_CMD : mme_pkg::SQ_SEC;
                                end
                            end
                        end
                    end
                    default: sq_st_ff <= mme_pkg::SQ_OFF;
                endcase
            end
        end
    end

    a_break_after_sec: assert property (brk_sent_ff |-> sec_cnt_ff == 4'h8) // [RL4]
        else $error("break sent before eight security bytes");
    a_byte_echo: assert property (ce && rx_byte_ff && rx_on && reset_pin_n && mode.monitor
        && !extra_reset |=> sq_st_ff == mme_pkg::SQ_DELAY && tx_shift_ff[8:1] == $past(rx_shift_ff)) // [RL19]
        else $error("received byte not queued for echo");

    // security comparison against stored bytes; unlock lasts until power-on reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sec_bad_ff <= 1'b0;
            unlocked <= 1'b0;
        end else if (ce) begin
            if (sq_st_ff == mme_pkg::SQ_SEC && rx_byte_ff && rx_shift_ff != sec_byte) begin
                sec_bad_ff <= 1'b1; // [RL17]
            end
            if (sec_cnt_ff == mme_pkg::SEC_BYTES && !sec_bad_ff) begin
                unlocked <= 1'b1; // [RL17]
            end
        end
    end

    a_no_unlock_bad: assert property (ce && sec_bad_ff && !unlocked |=> !unlocked) // [RL17]
        else $error("unlocked after a security mismatch");

    // pin drive: the line is released except while this end is sending or holds it high after a break
    always_comb begin
        nxt_out = 1'b1;
        nxt_oe_n = 1'b1;
        if (sq_st_ff == mme_pkg::SQ_TX) begin
            nxt_out = tx_shift_ff[0]; // [RL1] [RL13]
            nxt_oe_n = 1'b0;
        end else if (sq_st_ff == mme_pkg::SQ_DELAY && hold_hi_ff) begin
            nxt_out = 1'b1; // [RL18]
            nxt_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            comm_out <= 1'b1;
            comm_oe_n <= 1'b1;
        end else if (ce) begin
            comm_out <= nxt_out;
            comm_oe_n <= nxt_oe_n;
        end
    end

    a_tx_break_zero: assert property (ce && sq_st_ff == mme_pkg::SQ_TX && tx_brk_ff |=> !comm_out && !comm_oe_n) // [RL4]
        else $error("break frame not driven low");

    // register port: read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_rx_ff <= 8'h00;
        end else if (ce && rx_byte_ff) begin
            last_rx_ff <= rx_shift_ff;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            reg_rdata <= mme_pkg::RESERVED_READ;
            if (reg_rd && reg_addr == mme_pkg::REG_STATUS) begin
                reg_rdata[mme_pkg::ST_MONITOR] <= mode.monitor;
                reg_rdata[mme_pkg::ST_FORCED] <= mode.forced;
                reg_rdata[mme_pkg::ST_UNLOCKED] <= unlocked;
                reg_rdata[mme_pkg::ST_BREAK_SENT] <= brk_sent_ff;
                reg_rdata[mme_pkg::ST_SEC_CNT +: 4] <= sec_cnt_ff;
            end else if (reg_rd && reg_addr == mme_pkg::REG_LAST_RX) begin
                reg_rdata <= last_rx_ff;
            end
        end
    end
endmodule
`default_nettype wire

// *** mmel_host.sv ***
// Purpose: host side of the single-wire monitor link
// Assumes: bit time is given in clk cycles
// Notes: the line is released between frames so the pullup sets it high
`timescale 1ns/100ps
`default_nettype none
module mmel_host (
    input wire logic clk,
    input wire logic line,
    output logic drv_low
);
    initial drv_low = 1'b0;

    // wired-OR: the host only ever pulls low
    task automatic send(input logic [7:0] b, input int t);
        logic [9:0] f;
        f = {1'b1, b, 1'b0}; // start 0, lsb first, stop 1
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            drv_low <= !f[i];
            repeat (t - 1) @(posedge clk);
        end
        @(posedge clk);
        drv_low <= 1'b0;
    endtask

    // break: line held low for ten bit times
    task automatic brk(input int t);
        @(posedge clk);
        drv_low <= 1'b1;
        repeat (10 * t) @(posedge clk);
        drv_low <= 1'b0;
    endtask

    // limitation: start length is measured up to the first high bit, so bit 0 must be 1
    task automatic recv(input int t, output logic [7:0] b, output int lo, output logic ok);
        int n;
        ok = 1'b0;
        b = 8'h00;
        lo = 0;
        n = 0;
        // sampled on the falling edge, where the registered line has settled
        @(negedge clk);
        while (line !== 1'b0 && n < 20 * t) begin
            @(negedge clk);
            n++;
        end
        while (line === 1'b0 && lo < 2 * t) begin
            @(negedge clk);
            lo++;
        end
        for (int i = 0; i < 8; i++) begin
            repeat ((i == 0) ? t / 2 : t) @(negedge clk);
            b[i] = line;
        end
        ok = (n < 20 * t);
    endtask
endmodule
`default_nettype wire

// *** test_monitor_mode_entry_link.sv ***
// Purpose: self-checking bench of the monitor-mode entry and serial link block
// Assumes: ce held high; normal entry with divider low runs the bus at half the input clock
// Notes: the readiness break needs all eight security bytes, too long for this run
`timescale 1ns/100ps
`default_nettype none
module test_monitor_mode_entry_link;
    typedef struct packed {
        logic [6:0] s;
        logic [4:0] m;
    } mmel_row_t;
    localparam int bit_clks = 2 * mme_pkg::BAUD_BUS_CYCLES;
    logic clk, arst_n, reg_wr, reg_rd, reset_pin_n, drv_low, ok;
    logic comm_out, comm_oe_n, extra_reset, unlocked;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rx, tx;
    logic [15:0] reset_vec, swi_brk_vec;
    mme_pkg::mme_strap_t strap;
    mme_pkg::mme_mode_t mode;
    wire logic line;
    int num_errors, n_compared, n_extra, lo;
    // straps: normal low/high divider, forced, user, normal with serial select high
    mmel_row_t rows [5] = '{'{7'h44, 5'h16}, '{7'h54, 5'h13}, '{7'h13, 5'h1B}, '{7'h04, 5'h01},
                           '{7'h4C, 5'h01}};

    assign line = drv_low ? 1'b0 : (comm_oe_n ? 1'b1 : comm_out);

    mme_top dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_pin_n(reset_pin_n),
        .strap(strap), .comm_in(line), .comm_out(comm_out), .comm_oe_n(comm_oe_n), .mode(mode),
        .reset_vec(reset_vec), .swi_brk_vec(swi_brk_vec), .extra_reset(extra_reset),
        .unlocked(unlocked));
    mmel_host host (.clk(clk), .line(line), .drv_low(drv_low));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (extra_reset === 1'b1) begin
            n_extra++;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // host holds straps and a high comm line while the reset pin rises
    task automatic enter(input logic [6:0] s);
        @(posedge clk);
        arst_n <= 1'b0;
        reset_pin_n <= 1'b0;
        strap <= s;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        arst_n = 1'b0;
        reset_pin_n = 1'b0;
        strap = '0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (10) @(posedge clk);
        check("released line", 1'b1, comm_oe_n);
        check("reset vectors", {mme_pkg::USER_RESET_VEC, mme_pkg::USER_SWI_VEC}, {reset_vec, swi_brk_vec});
        for (int i = 0; i < 5; i++) begin
            enter(rows[i].s);
            check("mode", rows[i].m, mode);
            check("vectors", rows[i].m[4] ? {mme_pkg::MON_RESET_VEC, mme_pkg::MON_SWI_VEC} :
                {mme_pkg::USER_RESET_VEC, mme_pkg::USER_SWI_VEC}, {reset_vec, swi_brk_vec});
        end
        check("extra resets", 1, n_extra);
        enter(7'h13);
        @(posedge clk);
        strap <= 7'h4C;
        repeat (4) @(posedge clk);
        check("forced after strap change", 5'h1B, mode);
        enter(7'h44);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= mme_pkg::REG_SEC_BASE;
        reg_wdata <= 8'hA5;
        @(posedge clk);
        reg_wr <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            tx = i ? 8'h3D : 8'hA5;
            host.send(tx, bit_clks);
            host.recv(bit_clks, rx, lo, ok);
            check("echo seen", 1'b1, ok);
            check("echo byte", tx, rx);
            check("bit time", bit_clks, lo);
            // echo still runs 1.5 bit times, then 1.5 bit times of spacing
            repeat (3 * bit_clks) @(posedge clk);
        end
        host.brk(bit_clks);
        check("break hold drive", 2'b01, {comm_oe_n, comm_out});
        host.recv(bit_clks, rx, lo, ok);
        check("break echo seen", 1'b1, ok);
        check("break echo low", 2 * bit_clks, lo);
        check("break echo data", 8'h00, rx);
        check("unlocked", 1'b0, unlocked);
        reg_read(mme_pkg::REG_LAST_RX, rx);
        check("last byte", 8'h3D, rx);
        reg_read(mme_pkg::REG_STATUS, rx);
        check("status", 8'h21, rx);
        reg_read(4'h5, rx);
        check("unmapped read", mme_pkg::RESERVED_READ, rx);
        strap <= 7'h04;
        repeat (4) @(posedge clk);
        check("watchdog without test voltage", 1'b0, mode.wd_disable);
        strap <= 7'h24;
        repeat (4) @(posedge clk);
        check("watchdog test voltage on reset pin", 1'b1, mode.wd_disable);
        end_of_test();
    end
endmodule
`default_nettype wire
